//--- design/vagd_decoder.sv
// alu clause group decoder: slot intake, group issue, writeback and apb status
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module vagd_decoder
  import vagd_pkg::*;
#(
  parameter int LEN_W = 8
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // clause launch from sequencer
  input  wire logic                    launch_valid,
  input  wire logic [LEN_W-1:0]        launch_len,
  output logic                         launch_ready,
  output logic                         clause_done,
  // slot stream
  input  wire logic                    slot_valid,
  input  wire logic [SLOT_W-1:0]       slot_data,
  output logic                         slot_ready,
  // index sources
  input  wire logic [7:0]              loop_counter_index,
  input  wire logic [7:0]              index_reg_value,
  // group issue to lanes
  output logic                         issue_valid,
  input  wire logic                    issue_ready,
  output vagd_lane_t [LANES-1:0]       issue_lanes,
  // lane results and register writeback
  input  wire logic                    result_valid,
  input  wire logic [VEC_W-1:0]        result_data,
  output logic                         result_ready,
  output logic                         wb_valid,
  output vagd_wb_t                     wb_out
);

  if (LEN_W < 3 || LEN_W > 16) begin : g_len_bad
    $error("LEN_W must lie in 3..16");
  end

  vagd_state_t             state_reg;
  logic [LEN_W-1:0]        len_reg;
  logic [LEN_W-1:0]        slot_cnt_reg;
  logic [LANES-1:0][63:0]  raw_reg;
  logic [LANES-1:0]        lane_v_reg;
  logic [1:0]              last_lane_reg;
  logic [1:0]              lit_need_reg;
  logic                    lit_got_reg;
  logic [VEC_W-1:0]        lits_reg;
  logic [VEC_W-1:0]        pv_reg;
  vagd_lane_t [LANES-1:0]  issue_reg;
  vagd_lane_t [LANES-1:0]  issue_next;
  vagd_wb_t                wb_reg;
  logic                    wb_valid_reg;
  logic                    done_reg;
  logic                    en_reg;
  logic [2:0]              err_reg;
  logic [2:0]              err_set;
  logic [2:0]              err_clr;
  logic [15:0]             groups_reg;
  logic [31:0]             prdata_reg;
  logic [31:0]             rd_mux;
  logic                    slot_take;
  logic                    clause_end;
  logic                    is_last;
  logic [1:0]              lane;
  logic                    order_bad;
  logic [1:0]              need_all;
  logic                    lit_done;
  logic                    res_take;

  // operand format of a slot: three-source when any top opcode bit is set
  function automatic logic three_src(input logic [63:0] w);
    return |w[WORD_W+W1_OP_MSB -: 3];
  endfunction

  // literal slots needed by one instruction: bit0 first, bit1 second
  function automatic logic [1:0] need_lits(input logic [63:0] w);
    logic [1:0] n;
    n = 2'b00;
    if (w[W0_SA +: 9] == inline_literal_select) n = n | {w[W0_SA_CH+1], 1'b1};
    if (w[W0_SB +: 9] == inline_literal_select) n = n | {w[W0_SB_CH+1], 1'b1};
    if (three_src(w) && w[WORD_W+W1_SC +: 9] == inline_literal_select)
      n = n | {w[WORD_W+W1_SC_CH+1], 1'b1};
    return n;
  endfunction

  // resolve one source select into a register reference or a ready value
  function automatic vagd_opnd_t resolve(input logic [8:0] sel, input logic rel,
                                         input logic [1:0] ch, input logic [7:0] idx,
                                         input logic [VEC_W-1:0] lits,
                                         input logic [VEC_W-1:0] pv);
    vagd_opnd_t o;
    logic [7:0] off;
    o = '0;
    off = rel ? idx : 8'h00;
    o.chan = ch;
    if (sel >= SEL_CONST) begin
      o.kind = K_CONST;
      o.addr = sel[7:0] + off;
    end else if (sel <= SEL_GPR_MAX) begin
      o.kind = K_GPR;
      o.addr = {1'b0, 7'(sel[6:0] + off[6:0])};
    end else begin
      o.kind = K_VALUE;
      case (sel)
        SEL_ZERO:              o.value = 32'h00000000;
        SEL_ONE_INT:           o.value = 32'h00000001;
        SEL_MINUS_ONE:         o.value = 32'hffffffff;
        SEL_HALF:              o.value = FP_HALF;
        SEL_ONE_F:             o.value = FP_ONE;
        inline_literal_select: o.value = lits[{ch, 5'h00} +: 32];
        SEL_PREV:              o.value = pv[{ch, 5'h00} +: 32];
        default:               o.value = 32'h00000000;
      endcase
    end
    return o;
  endfunction

  // decode one stored slot into the lane issue record
  function automatic vagd_lane_t build_lane(input logic v, input logic [63:0] w,
                                            input logic [VEC_W-1:0] lits,
                                            input logic [VEC_W-1:0] pv,
                                            input logic [7:0] lidx,
                                            input logic [7:0] ridx);
    vagd_lane_t r;
    logic [7:0] idx;
    logic       t;
    r = '0;
    t = three_src(w);
    idx = w[W0_IDX] ? ridx : lidx;
    r.valid = v;
    r.three_src = t;
    // five-bit opcode right-aligned for the three-source form
    r.opcode = t ? {5'h00, w[WORD_W+W1_OP_MSB -: 5]} : w[WORD_W+W1_OP_MSB -: 10];
    r.src[0] = resolve(w[W0_SA +: 9], w[W0_SA_REL], w[W0_SA_CH +: 2], idx, lits, pv);
    r.src[1] = resolve(w[W0_SB +: 9], w[W0_SB_REL], w[W0_SB_CH +: 2], idx, lits, pv);
    if (t) begin
      r.src[2] = resolve(w[WORD_W+W1_SC +: 9], w[WORD_W+W1_SC_REL],
                         w[WORD_W+W1_SC_CH +: 2], idx, lits, pv);
      r.omod = 2'b00;
    end else begin
      r.omod = w[WORD_W+W1_OMOD +: 2];
    end
    r.dst = w[WORD_W+W1_DST +: 7] + (w[WORD_W+W1_DREL] ? idx[6:0] : 7'h00);
    r.clamp = w[WORD_W+W1_CLAMP];
    if (!v) r = '0;
    return r;
  endfunction

  // output modifier: scale by exponent bump, then clamp to unit range
  function automatic logic [31:0] lane_post(input logic [31:0] v, input logic clamp,
                                            input logic [1:0] omod);
    logic [31:0] r;
    logic [8:0]  e;
    r = v;
    e = {1'b0, v[FP_EXP_MSB:FP_EXP_LSB]};
    // zero, denormal, inf and nan pass unscaled
    if (e != 9'h000 && e != FP_EXP_MAX) begin
      if (omod == OMOD_X2) e = e + 9'h001;
      else if (omod == OMOD_X4) e = e + 9'h002;
      if (e >= FP_EXP_MAX) begin
        r[FP_EXP_MSB:FP_EXP_LSB] = FP_EXP_MAX[7:0];
        r[FP_EXP_LSB-1:0] = '0;
      end else begin
        r[FP_EXP_MSB:FP_EXP_LSB] = e[7:0];
      end
    end
    if (clamp) begin
      if (r[31]) r = 32'h00000000;
      else if (r > FP_ONE) r = FP_ONE;
    end
    return r;
  endfunction

  // slot intake decode; word at +0 sits in the low half
  assign slot_ready = (state_reg == S_COLLECT) || (state_reg == S_LIT);
  assign slot_take  = slot_valid && slot_ready;
  assign clause_end = (slot_cnt_reg + LEN_W'(1)) == len_reg;
  assign is_last    = slot_data[W0_LAST];
  assign lane       = slot_data[WORD_W+W1_DCH +: 2];
  assign order_bad  = (lane_v_reg != '0) && (lane <= last_lane_reg);
  assign need_all   = lit_need_reg | need_lits(slot_data);
  assign lit_done   = !lit_need_reg[1] || lit_got_reg;
  assign res_take   = (state_reg == S_WAIT) && result_valid;

  // main sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (launch_valid && launch_ready && launch_len != '0) state_reg <= S_COLLECT;
        end
        S_COLLECT: begin
          if (slot_take && (is_last || clause_end)) begin
            // a truncated clause cannot deliver literals
            if (need_all != 2'b00 && !clause_end) state_reg <= S_LIT;
            else state_reg <= S_BUILD;
          end
        end
        S_LIT: begin
          if (slot_take && (lit_done || clause_end)) state_reg <= S_BUILD;
        end
        S_BUILD: state_reg <= S_ISSUE;
        S_ISSUE: begin
          if (issue_ready) state_reg <= S_WAIT;
        end
        S_WAIT: begin
          if (result_valid) state_reg <= (slot_cnt_reg == len_reg) ? S_IDLE : S_COLLECT;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // clause length and slot counter, every slot counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_reg      <= '0;
      slot_cnt_reg <= '0;
    end else if (state_reg == S_IDLE && launch_valid && launch_ready) begin
      len_reg      <= launch_len;
      slot_cnt_reg <= '0;
    end else if (slot_take) begin
      slot_cnt_reg <= slot_cnt_reg + LEN_W'(1);
    end
  end

  // group collection: lane slots then literal slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_reg       <= '0;
      lane_v_reg    <= '0;
      last_lane_reg <= '0;
      lit_need_reg  <= '0;
      lit_got_reg   <= 1'b0;
      lits_reg      <= '0;
    end else if (res_take || state_reg == S_IDLE) begin
      lane_v_reg   <= '0;
      lit_need_reg <= '0;
      lit_got_reg  <= 1'b0;
      lits_reg     <= '0;
    end else if (slot_take && state_reg == S_COLLECT) begin
      raw_reg[lane]    <= slot_data;
      lane_v_reg[lane] <= 1'b1;
      last_lane_reg    <= lane;
      lit_need_reg     <= need_all;
    end else if (slot_take && state_reg == S_LIT) begin
      // first literal slot holds x,y; second holds z,w
      if (!lit_got_reg) lits_reg[63:0] <= slot_data;
      else lits_reg[127:64] <= slot_data;
      lit_got_reg <= 1'b1;
    end
  end

  // issue record, built once all slots of the group are in
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      issue_next[l] = build_lane(lane_v_reg[l], raw_reg[l], lits_reg, pv_reg,
                                 loop_counter_index, index_reg_value);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      issue_reg <= '0;
    end else if (state_reg == S_BUILD) begin
      issue_reg <= issue_next;
    end
  end

  assign issue_valid  = (state_reg == S_ISSUE);
  assign issue_lanes  = issue_reg;
  assign result_ready = (state_reg == S_WAIT);

  // writeback and previous-result vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_reg       <= '0;
      wb_valid_reg <= 1'b0;
      pv_reg       <= '0;
    end else begin
      wb_valid_reg <= res_take;
      if (res_take) begin
        for (int l = 0; l < LANES; l++) begin
          // each lane lands only in its own element
          wb_reg.data[l*WORD_W +: WORD_W] <= issue_reg[l].valid ?
            lane_post(result_data[l*WORD_W +: WORD_W], issue_reg[l].clamp,
                      issue_reg[l].omod) : 32'h00000000;
          wb_reg.addr[l] <= issue_reg[l].dst;
          wb_reg.mask[l] <= issue_reg[l].valid;
          // nop lanes leave zero behind, never a stale value
          pv_reg[l*WORD_W +: WORD_W] <= (issue_reg[l].valid && slot_cnt_reg != len_reg) ?
            lane_post(result_data[l*WORD_W +: WORD_W], issue_reg[l].clamp,
                      issue_reg[l].omod) : 32'h00000000;
        end
      end else if (state_reg == S_IDLE) begin
        pv_reg <= '0;
      end
    end
  end

  assign wb_valid = wb_valid_reg;
  assign wb_out   = wb_reg;

  // clause completion pulse and group count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg   <= 1'b0;
      groups_reg <= '0;
    end else begin
      done_reg <= res_take && (slot_cnt_reg == len_reg);
      if (res_take) groups_reg <= groups_reg + 16'h0001;
    end
  end

  assign clause_done  = done_reg;
  assign launch_ready = (state_reg == S_IDLE) && en_reg;

  // sticky error causes
  always_comb begin
    err_set = 3'b000;
    err_set[ERR_ORDER] = slot_take && state_reg == S_COLLECT && order_bad;
    err_set[ERR_OVERRUN] = slot_take && state_reg == S_COLLECT && clause_end && !is_last;
    err_set[ERR_LIT] = slot_take && clause_end &&
                       ((state_reg == S_COLLECT && is_last && need_all != 2'b00) ||
                        (state_reg == S_LIT && !lit_done));
  end

  // apb write strobes
  assign err_clr = (psel && penable && pwrite && paddr == REG_STATUS) ? pwdata[2:0] : 3'b000;

  // a new error in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= '0;
    end else begin
      err_reg <= (err_reg & ~err_clr) | err_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 1'b0;
    end else if (psel && penable && pwrite && paddr == REG_CTRL) begin
      en_reg <= pwdata[CTRL_EN];
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      REG_CTRL:   rd_mux[CTRL_EN] = en_reg;
      REG_STATUS: rd_mux = 32'(err_reg) | (32'(state_reg != S_IDLE) << STAT_BUSY);
      REG_GROUPS: rd_mux = {16'h0000, groups_reg};
      REG_SLOTS:  rd_mux = {{(32-LEN_W){1'b0}}, slot_cnt_reg};
      REG_PV_X:   rd_mux = pv_reg[31:0];
      REG_PV_Y:   rd_mux = pv_reg[63:32];
      REG_PV_Z:   rd_mux = pv_reg[95:64];
      REG_PV_W:   rd_mux = pv_reg[127:96];
      default:    rd_mux = 32'h00000000;
    endcase
  end

  // read data captured in the setup cycle, answered with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (psel && !penable) begin
      prdata_reg <= rd_mux;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr > REG_PV_W || paddr[1:0] != 2'b00);

endmodule

//--- design/vagd_pkg.sv
// constants, types and field layout shared by the alu group decoder
//
// Behaviour
// - each instruction slot is two 32-bit words, first at +0, second at +4
// - a group holds one to four lane instructions plus zero to two literal slots
// - the instruction with the group-end flag set closes the group
// - literal use demands the first literal slot; second never alone
// - literal slots have no end flag; count comes from operand selects
// - first literal slot gives x then y, second gives z then w
// - lane slot equals destination channel, one per lane, absent lanes are nops
// - previous-result vector keeps last group's four lane outputs as a source
// - vectors are 128 bits, lane x in bits 31:0, lane w in 127:96
// - each lane writes only its own element, addresses may differ per lane
// - optional clamp to 0.0..1.0 and optional output scale by 2.0 or 4.0
// - each lane takes up to three 32-bit sources and yields one result
// - two-source word: 10-bit opcode field with top three bits zero
// - three-source word: five-bit opcode at same msb, top bits nonzero
// - two-source form has zero to two sources, three-source form three
// - operands reach 256 constants and 128 gprs, absolute or indexed
// - any source may pick built-in constants without a literal slot
// - double-precision ops span two or four slots, others one slot; the decoder takes every lane instruction as one slot
// - clause length counts all slots, literal slots included
// - nop lanes clear their previous result; vector cleared at clause end
package vagd_pkg;
  localparam int LANES  = 4;
  localparam int WORD_W = 32;
  localparam int SLOT_W = 64;
  localparam int VEC_W  = 128;
  // first word: two source selects, index mode, group end
  localparam int W0_SA     = 0;
  localparam int W0_SA_REL = 9;
  localparam int W0_SA_CH  = 10;
  localparam int W0_SB     = 13;
  localparam int W0_SB_REL = 22;
  localparam int W0_SB_CH  = 23;
  localparam int W0_IDX    = 26;
  localparam int W0_LAST   = 31;
  // second word, positions within that word
  localparam int W1_SC     = 0;
  localparam int W1_SC_REL = 9;
  localparam int W1_SC_CH  = 10;
  localparam int W1_OMOD   = 5;
  localparam int W1_OP_MSB = 17;
  localparam int W1_DST    = 21;
  localparam int W1_DREL   = 28;
  localparam int W1_DCH    = 29;
  localparam int W1_CLAMP  = 31;
  // source select codes
  localparam logic [8:0] SEL_GPR_MAX   = 9'h07f;
  localparam logic [8:0] SEL_ZERO      = 9'h0f8;
  localparam logic [8:0] SEL_ONE_INT   = 9'h0f9;
  localparam logic [8:0] SEL_MINUS_ONE = 9'h0fa;
  localparam logic [8:0] SEL_HALF      = 9'h0fb;
  localparam logic [8:0] SEL_ONE_F     = 9'h0fc;
  localparam logic [8:0] inline_literal_select = 9'h0fd;
  localparam logic [8:0] SEL_PREV      = 9'h0fe;
  localparam logic [8:0] SEL_CONST     = 9'h100;
  // float encodings
  localparam logic [31:0] FP_ONE  = 32'h3f800000;
  localparam logic [31:0] FP_HALF = 32'h3f000000;
  localparam int FP_EXP_LSB = 23;
  localparam int FP_EXP_MSB = 30;
  localparam logic [8:0] FP_EXP_MAX = 9'h0ff;
  localparam logic [1:0] OMOD_X2 = 2'h1;
  localparam logic [1:0] OMOD_X4 = 2'h2;
  // apb register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_GROUPS = 8'h08;
  localparam logic [7:0] REG_SLOTS  = 8'h0c;
  localparam logic [7:0] REG_PV_X   = 8'h10;
  localparam logic [7:0] REG_PV_Y   = 8'h14;
  localparam logic [7:0] REG_PV_Z   = 8'h18;
  localparam logic [7:0] REG_PV_W   = 8'h1c;
  localparam int CTRL_EN     = 0;
  localparam int ERR_ORDER   = 0;
  localparam int ERR_OVERRUN = 1;
  localparam int ERR_LIT     = 2;
  localparam int STAT_BUSY   = 8;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_COLLECT = 3'b001, S_LIT = 3'b010,
    S_BUILD = 3'b011, S_ISSUE = 3'b100, S_WAIT = 3'b101
  } vagd_state_t;
  typedef enum logic [1:0] {K_GPR = 2'b00, K_CONST = 2'b01, K_VALUE = 2'b10} vagd_kind_t;
  typedef struct packed {
    vagd_kind_t  kind;
    logic [7:0]  addr;
    logic [1:0]  chan;
    logic [31:0] value;
  } vagd_opnd_t;
  typedef struct packed {
    logic             valid;
    logic             three_src;
    logic [9:0]       opcode;
    vagd_opnd_t [2:0] src;
    logic [6:0]       dst;
    logic             clamp;
    logic [1:0]       omod;
  } vagd_lane_t;
  typedef struct packed {
    logic [3:0]      mask;
    logic [3:0][6:0] addr;
    logic [127:0]    data;
  } vagd_wb_t;
endpackage

//--- tb/vagd_decoder_chk.sv
// port-level assertions for the alu group decoder
`timescale 1ns/10ps
module vagd_decoder_chk
  import vagd_pkg::*;
#(
  parameter int LEN_W = 8
) (
  // clock, reset, apb
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  // clause and slot flow
  input wire logic                  launch_valid,
  input wire logic                  launch_ready,
  input wire logic [LEN_W-1:0]      launch_len,
  input wire logic                  slot_ready,
  input wire logic                  clause_done,
  // issue and results
  input wire logic                  issue_valid,
  input wire logic                  issue_ready,
  input wire vagd_lane_t [LANES-1:0] issue_lanes,
  input wire logic                  result_valid,
  input wire logic                  result_ready,
  input wire logic                  wb_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // refused addresses answer with error and zero data
  AST_APB_ERR: assert property (psel && penable && (paddr > 8'h1c || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("bad address not refused");
  AST_ERR_RD_ZERO: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_LAUNCH: assert property (launch_valid && launch_ready && launch_len != 0 |=> slot_ready)
    else $error("slot intake did not open after launch");
  AST_ISSUE_HOLD: assert property (issue_valid && !issue_ready |=> issue_valid && $stable(issue_lanes))
    else $error("issued group changed while stalled");
  AST_ISSUE_GATE: assert property (issue_valid |-> !slot_ready && !result_ready)
    else $error("intake open during issue");
  AST_ISSUE_SINGLE: assert property (issue_valid && issue_ready |=> !issue_valid && result_ready)
    else $error("group issued twice");
  AST_WB_ONE: assert property (result_valid && result_ready |=> wb_valid ##1 !wb_valid)
    else $error("writeback not a single pulse after result");
  AST_DONE_IDLE: assert property (clause_done |-> !slot_ready && !issue_valid)
    else $error("clause end while still busy");
  AST_DONE_ONE: assert property (clause_done |=> !clause_done)
    else $error("clause end longer than one cycle");
  // main scenarios
  COV_WB: cover property (wb_valid);
  COV_DONE: cover property (clause_done);
  COV_ERR: cover property (psel && penable && pslverr);
endmodule

//--- tb/vagd_seq_model.sv
// behavioural sequencer: clause launch and slot feed
`timescale 1ns/10ps
module vagd_seq_model #(
  parameter int LEN_W = 8
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // launch handshake
  input  wire logic        launch_ready,
  output logic             launch_valid,
  output logic [LEN_W-1:0] launch_len,
  // slot stream
  input  wire logic        slot_ready,
  output logic             slot_valid,
  output logic [63:0]      slot_data
);
  logic [63:0] q [$];
  logic        slow = 1'b0, gap;
  task automatic push(input logic [63:0] s);
    q.push_back(s);
  endtask
  // clause length counts every slot, literals too
  task automatic start(input logic [LEN_W-1:0] n);
    launch_len <= n;
    launch_valid <= 1'b1;
  endtask
  // requests held until taken; idle data scrambled so nothing stale looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launch_valid <= 1'b0;
      launch_len <= '0;
      slot_valid <= 1'b0;
      slot_data <= 64'h0;
      gap <= 1'b0;
    end else begin
      if (launch_valid && launch_ready)
        launch_valid <= 1'b0;
      if (!slot_valid || slot_ready) begin
        if (slot_valid)
          void'(q.pop_front());
        gap <= slow & ~gap;
        if (q.size() != 0 && !gap) begin
          slot_valid <= 1'b1;
          slot_data <= q[0];
        end else begin
          slot_valid <= 1'b0;
          slot_data <= ~slot_data;
        end
      end
    end
  end
endmodule

//--- tb/vagd_decoder_tb.sv
// self-checking bench for the alu group decoder
`timescale 1ns/10ps
module vagd_decoder_tb;
  import vagd_pkg::*;
  localparam int LEN_W = 8;
  typedef struct packed {logic [8:0] sel; logic [2:0] op3; logic [31:0] val; logic three;} vagd_row_t;
  vagd_row_t rows [6] = '{'{SEL_ZERO, 3'h0, 32'h0, 1'b0}, '{SEL_ONE_INT, 3'h0, 32'h1, 1'b0},
    '{SEL_MINUS_ONE, 3'h0, 32'hffffffff, 1'b0}, '{SEL_HALF, 3'h1, FP_HALF, 1'b1},
    '{SEL_ONE_F, 3'h0, FP_ONE, 1'b0}, '{SEL_ZERO, 3'h4, 32'h0, 1'b1}};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic issue_ready = 1'b0, result_valid = 1'b0;
  logic [7:0] paddr = 8'h0, lci = 8'h05, irv = 8'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [127:0] res_vec = {FP_ONE, 32'h40000000, 32'h12345678, 32'h0};
  int checked = 0, miscompares = 0, cyc = 0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, launch_valid, launch_ready, clause_done, slot_valid, slot_ready;
  wire logic issue_valid, result_ready, wb_valid;
  wire logic [LEN_W-1:0] launch_len;
  wire logic [63:0] slot_data;
  vagd_lane_t [LANES-1:0] issue_lanes;
  vagd_wb_t wb_out;
  vagd_decoder #(.LEN_W(LEN_W)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .launch_valid(launch_valid), .launch_len(launch_len), .launch_ready(launch_ready),
    .clause_done(clause_done), .slot_valid(slot_valid), .slot_data(slot_data), .slot_ready(slot_ready),
    .loop_counter_index(lci), .index_reg_value(irv), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_lanes(issue_lanes), .result_valid(result_valid), .result_data(res_vec),
    .result_ready(result_ready), .wb_valid(wb_valid), .wb_out(wb_out));
  vagd_seq_model #(.LEN_W(LEN_W)) seq (.pclk(pclk), .presetn(presetn), .launch_ready(launch_ready),
    .launch_valid(launch_valid), .launch_len(launch_len), .slot_ready(slot_ready),
    .slot_valid(slot_valid), .slot_data(slot_data));
  always #25 pclk = ~pclk;
  // lanes stall one cycle on each handshake; timeout guard
  always @(posedge pclk) begin
    issue_ready <= issue_valid & ~issue_ready;
    result_valid <= result_ready & ~result_valid;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      print_verdict;
    end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // slot: lane, src a rel+sel/chan, src b sel/chan, end flag, opcode top bits, clamp, scale
  function automatic logic [63:0] mk(input logic [1:0] ln, input logic [9:0] sa, input logic [1:0] ca,
    input logic [8:0] sb, input logic [1:0] cb, input logic lst, input logic [2:0] op3,
    input logic clp, input logic [1:0] om);
    return {clp, ln, 1'b0, 5'h01, ln, 3'h0, op3, 7'h01, 1'b0, om, 5'h0,
            lst, 6'h0, cb, 1'b0, sb, 1'b0, ca, sa};
  endfunction
  task go(input logic [7:0] n);
    @(posedge pclk);
    seq.start(n);
  endtask
  // 0 issue, 1 writeback, 2 back to idle
  task wt(input int w);
    do @(posedge pclk);
    while (!(w == 0 ? issue_valid === 1'b1 : w == 1 ? wb_valid === 1'b1 : launch_ready === 1'b1));
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    foreach (rows[i]) begin
      seq.push(mk(2'h0, rows[i].sel, 2'h0, SEL_ZERO, 2'h0, 1'b1, rows[i].op3, 1'b0, 2'h0));
      go(8'h01);
      wt(0);
      chk(issue_lanes[0].src[0].value, rows[i].val);
      chk(issue_lanes[0].three_src, rows[i].three);
      wt(1);
      chk(wb_out.mask, 4'h1);
      wt(2);
    end
    // both literal slots needed by a z-element pick
    seq.push(mk(2'h0, inline_literal_select, 2'h2, inline_literal_select, 2'h1, 1'b1, 3'h0, 1'b0, 2'h0));
    seq.push({32'hb1, 32'ha1});
    seq.push({32'hd1, 32'hc1});
    go(8'h03);
    wt(0);
    chk(issue_lanes[0].src[0].value, 32'hc1);
    chk(issue_lanes[0].src[1].value, 32'hb1);
    wt(2);
    // slow feed: three-lane group, then a group reading the previous result
    seq.slow = 1'b1;
    seq.push(mk(2'h1, {1'b1, 9'h010}, 2'h0, SEL_ZERO, 2'h0, 1'b0, 3'h0, 1'b0, 2'h0));
    seq.push(mk(2'h2, SEL_ZERO, 2'h0, SEL_ZERO, 2'h0, 1'b0, 3'h0, 1'b1, 2'h0));
    seq.push(mk(2'h3, SEL_ZERO, 2'h0, SEL_ZERO, 2'h0, 1'b1, 3'h0, 1'b0, OMOD_X2));
    seq.push(mk(2'h0, SEL_PREV, 2'h1, SEL_PREV, 2'h0, 1'b1, 3'h0, 1'b0, 2'h0));
    go(8'h04);
    wt(1);
    chk(wb_out.mask, 4'he);
    chk({issue_lanes[1].src[0].kind, issue_lanes[1].src[0].addr}, {K_GPR, 8'h15});
    chk(wb_out.addr[2], 7'h06);
    chk(wb_out.data[127:32], {32'h40000000, FP_ONE, 32'h12345678});
    wt(0);
    chk(issue_lanes[0].src[0].value, 32'h12345678);
    chk(issue_lanes[0].src[1].value, 32'h0);
    wt(2);
    apb(1'b0, REG_PV_Y, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    print_verdict;
  end
endmodule
bind vagd_decoder vagd_decoder_chk #(.LEN_W(LEN_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .launch_valid(launch_valid), .launch_ready(launch_ready), .launch_len(launch_len),
  .slot_ready(slot_ready), .clause_done(clause_done), .issue_valid(issue_valid),
  .issue_ready(issue_ready), .issue_lanes(issue_lanes), .result_valid(result_valid),
  .result_ready(result_ready), .wb_valid(wb_valid));
